// ==== hw/overcurrent_logic.sv ====
// Two-stage phase overcurrent decision logic with trip-test sequencer.
// Assumes currents and settings come from same-clock logic; buttons,
// blocking inputs and switches are pins and pass a synchroniser.
//
// What this block does
// - Reset held ten seconds on register 0 enters trip-test; digits and knob 1 flash.
// - In test, each one-second reset press advances the selected knob indicator.
// - Knob 1 selected plus both buttons forces low start and yellow indicator.
// - Knob 2 selected plus both buttons forces low trip and red indicator.
// - Knobs 3 and 4 force high start and high trip the same way.
// - Step at no-indicator position raises self-supervision after five seconds, then exits.
// - Reset held ten seconds at any selection in ST_TEST leaves test mode; the IRF wait and pulse ignore it.
// - A permanent internal fault lights the supervision indicator and raises the alarm.
// - Fault code shows red 1 plus three digits; only rst_n clears it, not button or serial resets.
// - Stage starts when a phase exceeds its start value; start and yellow on.
// - Started stage over its operate delay trips and lights red.
// - Indicators self-reset or latch; latched cleared by reset or serial commands.
// - Blocking inputs inhibit low and high stages when routed by switches.
// - Switch 3 picks definite or inverse time; switches 1, 2 pick range.
// - Switches 7 and 8 pick one of three high-stage delay ranges.
// - Switch 4 latches trips until both buttons or a serial reset.
// - Switch 5 doubles high start value while a starting situation lasts.
// - Starting situation: rise from under 0.12 to over 3.0 low-set within 60 ms.
// - Starting situation ends when currents fall below 2.0 low-set.
// - Switch 6 selects the high-set threshold range.
// - Infinite high setting keeps the high stage from ever starting or tripping.
// - Forced test outputs hold only while both buttons stay pressed.
// - Idle trip-test returns to normal after about five minutes.
`timescale 1ns/100ps
`default_nettype none

module overcurrent_logic #(
  parameter int CUR_W    = 12,
  parameter int DLY_W    = 12,
  parameter int TICK_DIV = overcurrent_pkg::TICK_CYC
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [CUR_W-1:0] phase_a,
  input  wire logic [CUR_W-1:0] phase_b,
  input  wire logic [CUR_W-1:0] phase_c,
  input  wire logic [2:0]       phase_en,
  input  wire logic [CUR_W-1:0] low_start_set,
  input  wire logic [CUR_W-1:0] high_start_set,
  input  wire logic             high_set_infinite,
  input  wire logic [DLY_W-1:0] low_delay_set,
  input  wire logic [DLY_W-1:0] high_delay_set,
  input  wire logic [3:0]       ind_latch_cfg,
  input  wire logic             step_btn,
  input  wire logic             reset_btn,
  input  wire logic             low_stage_block_in,
  input  wire logic             high_stage_block_in,
  input  wire logic [1:0]       block_route_switches,
  input  wire logic [7:0]       front_function_switches,
  input  wire logic             reg0_shown,
  input  wire logic             serial_reset_cmd_a,
  input  wire logic             serial_reset_cmd_b,
  input  wire logic             internal_fault,
  input  wire logic [9:0]       internal_fault_code,
  output logic                  low_stage_start,
  output logic                  low_stage_trip,
  output logic                  high_stage_start,
  output logic                  high_stage_trip,
  output logic                  self_supervision_alarm,
  output logic [1:0]            ind_yellow,
  output logic [1:0]            ind_red,
  output logic                  ind_supervision,
  output logic                  digit_flash,
  output logic [3:0]            knob_flash,
  output logic [1:0]            low_curve_group,
  output logic                  low_inverse_mode,
  output logic                  fault_code_valid,
  output logic [9:0]            fault_code
);
  import overcurrent_pkg::*;

  localparam int XW = CUR_W + 10;
  localparam int DW = DLY_W + 7;
  localparam int TW = $clog2(TICK_DIV + 1);

  function automatic logic [CUR_W-1:0] max3(input logic [CUR_W-1:0] a,
      input logic [CUR_W-1:0] b, input logic [CUR_W-1:0] c,
      input logic [2:0] en);
    logic [CUR_W-1:0] m;
    m = '0;
    if (en[0] && a > m) m = a;
    if (en[1] && b > m) m = b;
    if (en[2] && c > m) m = c;
    return m;
  endfunction

  // Three delay ranges, shared by both stages
  function automatic logic [6:0] range_scale(input logic [1:0] sel);
    logic [6:0] s;
    s = SCALE_1;
    if (sel == 2'b01) s = SCALE_10;
    if (sel[1]) s = SCALE_100;
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic       step_s;
  logic       reset_s;
  logic [1:0] blk_s;
  logic [1:0] route_s;
  logic [7:0] sw_s;

  pin_sync #(.WIDTH(14)) u_pins (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .pin_in ({step_btn, reset_btn, high_stage_block_in, low_stage_block_in,
              block_route_switches, front_function_switches}),
    .pin_out({step_s, reset_s, blk_s, route_s, sw_s})
  );

  // ----------------------------------------------------------------
  // Timebase prescaler
  // ----------------------------------------------------------------
  logic [TW-1:0] div_ff;
  logic [TW-1:0] nxt_div;
  logic          tick;

  // A one-cycle enable per tick keeps a single clock domain
  always_comb begin
    tick    = (div_ff == TW'(TICK_DIV - 1));
    nxt_div = tick ? '0 : div_ff + 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // ----------------------------------------------------------------
  // Current sampling and starting-situation detector
  // ----------------------------------------------------------------
  logic [CUR_W-1:0] samp_ff;
  logic [CUR_W-1:0] nxt_samp;
  logic [CNT_W-1:0] win_ff;
  logic [CNT_W-1:0] nxt_win;
  logic             inrush_ff;
  logic             nxt_inrush;
  logic [XW-1:0]    samp_x;
  logic [XW-1:0]    low_x;

  always_comb begin
    samp_x     = XW'(samp_ff) * XW'(FRAC_DEN);
    low_x      = XW'(low_start_set);
    nxt_samp   = samp_ff;
    nxt_win    = win_ff;
    nxt_inrush = inrush_ff;
    if (tick) begin
      nxt_samp = max3(phase_a, phase_b, phase_c, phase_en);
      if (samp_x < low_x * XW'(INR_LOW_NUM)) begin
        nxt_win = TK_INRUSH;
      end else if (win_ff != '0) begin
        nxt_win = win_ff - 1'b1;
      end
      if (win_ff != '0 && samp_x > low_x * XW'(INR_HIGH_NUM)) begin
        nxt_inrush = 1'b1;
      end else if (samp_x < low_x * XW'(INR_END_NUM)) begin
        nxt_inrush = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      samp_ff   <= '0;
      win_ff    <= '0;
      inrush_ff <= 1'b0;
    end else begin
      samp_ff   <= nxt_samp;
      win_ff    <= nxt_win;
      inrush_ff <= nxt_inrush;
    end
  end

  // ----------------------------------------------------------------
  // Stage timers, trip latches and indicators
  // ----------------------------------------------------------------
  logic [DW-1:0] tmr_ff [2];
  logic [DW-1:0] nxt_tmr [2];
  logic [1:0]    hold_ff;
  logic [1:0]    nxt_hold;
  logic [1:0]    yel_ff;
  logic [1:0]    nxt_yel;
  logic [1:0]    red_ff;
  logic [1:0]    nxt_red;
  logic [XW-1:0] thr [2];
  logic [DW-1:0] dly [2];
  logic [1:0]    st_start;
  logic [1:0]    st_trip;
  logic [1:0]    blocked;
  logic          serial_clr;
  logic          both_held;
  logic          rst_rise;
  logic          step_rise;
  logic          rst_prev_ff;
  logic          step_prev_ff;
  test_state_t   state_ff;

  always_comb begin
    serial_clr = serial_reset_cmd_a | serial_reset_cmd_b;
    both_held  = step_s & reset_s;
    rst_rise   = reset_s & ~rst_prev_ff;
    step_rise  = step_s & ~step_prev_ff;
    blocked    = blk_s & route_s;
    thr[0]     = XW'(low_start_set);
    thr[1]     = sw_s[SW_HRANGE] ? XW'(high_start_set)
               : XW'(high_start_set) * XW'(HRANGE_RATIO);
    if (sw_s[SW_DOUBLE] && inrush_ff) begin
      thr[1] = thr[1] << 1;
    end
    dly[0] = DW'(low_delay_set) * DW'(range_scale(sw_s[SW_LRANGE +: 2]));
    dly[1] = DW'(high_delay_set) * DW'(range_scale(sw_s[SW_HDLY +: 2]));
    for (int i = 0; i < 2; i++) begin
      st_start[i] = (XW'(samp_ff) > thr[i]) && !blocked[i];
      st_trip[i]  = st_start[i] && (tmr_ff[i] >= dly[i]);
      nxt_tmr[i]  = tmr_ff[i];
      if (!st_start[i]) begin
        nxt_tmr[i] = '0;
      end else if (tick && tmr_ff[i] < dly[i]) begin
        nxt_tmr[i] = tmr_ff[i] + 1'b1;
      end
    end
    if (high_set_infinite) begin
      st_start[1] = 1'b0;
      st_trip[1]  = 1'b0;
    end
    // Latched trips clear on both buttons outside the test sequence
    for (int i = 0; i < 2; i++) begin
      nxt_hold[i] = (sw_s[SW_LATCH] & st_trip[i])
                  | (hold_ff[i] & ~(serial_clr | (both_held & state_ff == ST_NORMAL)));
      nxt_yel[i]  = st_start[i] | (ind_latch_cfg[2*i] & yel_ff[i]
                  & ~(serial_clr | rst_rise));
      nxt_red[i]  = st_trip[i] | (ind_latch_cfg[2*i+1] & red_ff[i]
                  & ~(serial_clr | rst_rise));
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_ff[0] <= '0;
      tmr_ff[1] <= '0;
      hold_ff   <= '0;
      yel_ff    <= '0;
      red_ff    <= '0;
    end else begin
      tmr_ff[0] <= nxt_tmr[0];
      tmr_ff[1] <= nxt_tmr[1];
      hold_ff   <= nxt_hold;
      yel_ff    <= nxt_yel;
      red_ff    <= nxt_red;
    end
  end

  // ----------------------------------------------------------------
  // Trip-test sequencer
  // ----------------------------------------------------------------
  test_state_t      nxt_state;
  logic [2:0]       sel_ff;
  logic [2:0]       nxt_sel;
  logic [CNT_W-1:0] press_ff;
  logic [CNT_W-1:0] nxt_press;
  logic [CNT_W-1:0] ph_ff;
  logic [CNT_W-1:0] nxt_ph;
  logic             rst_adv;
  logic             rst_long;
  logic [3:0]       force_vec;

  always_comb begin
    nxt_press = reset_s ? press_ff : '0;
    if (reset_s && tick && press_ff != TK_ENTER) begin
      nxt_press = press_ff + 1'b1;
    end
    rst_adv   = reset_s && tick && press_ff == TK_STEP - 1'b1;
    rst_long  = reset_s && tick && press_ff == TK_ENTER - 1'b1;
    nxt_state = state_ff;
    nxt_sel   = sel_ff;
    nxt_ph    = ph_ff;
    case (state_ff)
      ST_NORMAL: begin
        nxt_ph = '0;
        if (reg0_shown && rst_long && !step_s) begin
          nxt_state = ST_TEST;
          nxt_sel   = SEL_LS;
        end
      end
      ST_TEST: begin
        if (step_s || reset_s) begin
          nxt_ph = '0;
        end else if (tick) begin
          nxt_ph = ph_ff + 1'b1;
        end
        if (rst_long || (tick && ph_ff == TK_IDLE - 1'b1)) begin
          nxt_state = ST_NORMAL;
        end else if (rst_adv && !step_s) begin
          nxt_sel = (sel_ff == SEL_IRF) ? SEL_LS : sel_ff + 1'b1;
        end else if (step_rise && !reset_s && sel_ff == SEL_IRF) begin
          nxt_state = ST_IRF_WAIT;
          nxt_ph    = '0;
        end
      end
      ST_IRF_WAIT: begin
        if (tick) begin
          nxt_ph = ph_ff + 1'b1;
        end
        if (tick && ph_ff == TK_IRF - 1'b1) begin
          nxt_state = ST_IRF_PULSE;
          nxt_ph    = '0;
        end
      end
      ST_IRF_PULSE: begin
        if (tick) begin
          nxt_ph = ph_ff + 1'b1;
        end
        if (tick && ph_ff == TK_PULSE - 1'b1) begin
          nxt_state = ST_NORMAL;
        end
      end
      default: begin
        nxt_state = ST_NORMAL;
      end
    endcase
    // Forced indicators drop the cycle either button lets go; stage outputs a cycle later
    force_vec = '0;
    if (state_ff == ST_TEST && both_held && sel_ff != SEL_IRF) begin
      force_vec[sel_ff[1:0]] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= ST_NORMAL;
      sel_ff       <= SEL_LS;
      press_ff     <= '0;
      ph_ff        <= '0;
      rst_prev_ff  <= 1'b0;
      step_prev_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      sel_ff       <= nxt_sel;
      press_ff     <= nxt_press;
      ph_ff        <= nxt_ph;
      rst_prev_ff  <= reset_s;
      step_prev_ff <= step_s;
    end
  end

  // ----------------------------------------------------------------
  // Self-supervision and registered outputs
  // ----------------------------------------------------------------
  logic       fault_ff;
  logic       nxt_fault;
  logic [9:0] code_ff;
  logic [9:0] nxt_code;
  logic [3:0] out_ff;
  logic [3:0] nxt_out;
  logic       alarm_ff;
  logic       nxt_alarm;
  logic [3:0] knob_ff;
  logic [3:0] nxt_knob;

  // Only a power-on reset clears the fault, so the code survives servicing
  always_comb begin
    nxt_fault = fault_ff | internal_fault;
    nxt_code  = (internal_fault && !fault_ff) ? internal_fault_code : code_ff;
    nxt_alarm = nxt_fault | (nxt_state == ST_IRF_PULSE);
    nxt_out   = {st_trip[1] | hold_ff[1], st_start[1],
                 st_trip[0] | hold_ff[0], st_start[0]} | force_vec;
    nxt_knob  = '0;
    if (nxt_state == ST_TEST && nxt_sel != SEL_IRF) begin
      nxt_knob[nxt_sel[1:0]] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fault_ff <= 1'b0;
      code_ff  <= FAULT_CODE_RST;
      alarm_ff <= 1'b0;
      out_ff   <= '0;
      knob_ff  <= '0;
    end else begin
      fault_ff <= nxt_fault;
      code_ff  <= nxt_code;
      alarm_ff <= nxt_alarm;
      out_ff   <= nxt_out;
      knob_ff  <= nxt_knob;
    end
  end

  assign low_stage_start        = out_ff[0];
  assign low_stage_trip         = out_ff[1];
  assign high_stage_start       = out_ff[2];
  assign high_stage_trip        = out_ff[3];
  assign self_supervision_alarm = alarm_ff;
  assign ind_supervision        = alarm_ff;
  assign ind_yellow             = yel_ff | {force_vec[2], force_vec[0]};
  assign ind_red                = red_ff | {force_vec[3], force_vec[1]};
  assign digit_flash            = (state_ff == ST_TEST);
  assign knob_flash             = knob_ff;
  assign low_curve_group        = sw_s[SW_LRANGE +: 2];
  assign low_inverse_mode       = sw_s[SW_IDMT];
  assign fault_code_valid       = fault_ff;
  assign fault_code             = code_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_enter_test;
    state_ff == ST_NORMAL && reg0_shown && rst_long && !step_s
      |=> state_ff == ST_TEST && sel_ff == SEL_LS;
  endproperty
  a_enter_test: assert property (p_enter_test) else $error("test entry missed");

  property p_advance;
    state_ff == ST_TEST && rst_adv && !step_s && !rst_long && sel_ff == SEL_LT |=> sel_ff == SEL_HS;
  endproperty
  a_advance: assert property (p_advance) else $error("selection did not advance");

  property p_force_low_start;
    state_ff == ST_TEST && sel_ff == SEL_LS && both_held |=> low_stage_start;
  endproperty
  a_force_low_start: assert property (p_force_low_start) else $error("low start not forced");

  property p_force_low_trip;
    state_ff == ST_TEST && sel_ff == SEL_LT && both_held |-> ind_red[0] ##1 low_stage_trip;
  endproperty
  a_force_low_trip: assert property (p_force_low_trip) else $error("low trip not forced");

  property p_force_release;
    !both_held && !st_start[0] && !st_start[1] |=> !low_stage_start && !high_stage_start;
  endproperty
  a_force_release: assert property (p_force_release) else $error("force outlived buttons");

  property p_irf_pulse;
    state_ff == ST_IRF_WAIT ##1 state_ff == ST_IRF_PULSE |-> self_supervision_alarm;
  endproperty
  a_irf_pulse: assert property (p_irf_pulse) else $error("test alarm missing");

  property p_fault_alarm;
    internal_fault |=> self_supervision_alarm && fault_code_valid;
  endproperty
  a_fault_alarm: assert property (p_fault_alarm) else $error("fault not signalled");

  property p_code_sticky;
    fault_code_valid |=> fault_code_valid && $stable(fault_code);
  endproperty
  a_code_sticky: assert property (p_code_sticky) else $error("fault code lost");

  property p_high_infinite;
    high_set_infinite && !force_vec[2] |=> !high_stage_start;
  endproperty
  a_high_infinite: assert property (p_high_infinite) else $error("infinite high set started");

  property p_block_low;
    blk_s[BR_LOW] && route_s[BR_LOW] |-> !st_start[0] && !st_trip[0];
  endproperty
  a_block_low: assert property (p_block_low) else $error("blocked low stage acted");

endmodule
`default_nettype wire

// ==== hw/overcurrent_pkg.sv ====
// Constants shared by the two-stage overcurrent decision logic.
// Assumes a 10 MHz system clock and a 1 ms timebase tick.
package overcurrent_pkg;

  // ----------------------------------------------------------------
  // Clock and timebase
  // ----------------------------------------------------------------
  localparam int CLK_NS   = 100;
  localparam int TICK_NS  = 1000000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS; // Cycles per tick
  localparam int TICK_MS  = 1;

  // ----------------------------------------------------------------
  // Human-scale durations, in ms, and their counts in ticks
  // ----------------------------------------------------------------
  localparam int T_STEP_MS   = 1000;
  localparam int T_ENTER_MS  = 10000;
  localparam int T_IRF_MS    = 5000;
  localparam int T_PULSE_MS  = 500;
  localparam int T_IDLE_MS   = 300000;
  localparam int T_INRUSH_MS = 60;
  localparam int CNT_W       = 19;
  localparam logic [CNT_W-1:0] TK_STEP   = CNT_W'(T_STEP_MS / TICK_MS);
  localparam logic [CNT_W-1:0] TK_ENTER  = CNT_W'(T_ENTER_MS / TICK_MS);
  localparam logic [CNT_W-1:0] TK_IRF    = CNT_W'(T_IRF_MS / TICK_MS);
  localparam logic [CNT_W-1:0] TK_PULSE  = CNT_W'(T_PULSE_MS / TICK_MS);
  localparam logic [CNT_W-1:0] TK_IDLE   = CNT_W'(T_IDLE_MS / TICK_MS);
  localparam logic [CNT_W-1:0] TK_INRUSH = CNT_W'(T_INRUSH_MS / TICK_MS);

  // ----------------------------------------------------------------
  // Threshold ratios, as fractions of FRAC_DEN
  // ----------------------------------------------------------------
  localparam int FRAC_DEN     = 100;
  localparam int INR_LOW_NUM  = 12;   // 0.12 x low-set
  localparam int INR_HIGH_NUM = 300;  // 3.0 x low-set
  localparam int INR_END_NUM  = 200;  // 2.0 x low-set
  localparam int HRANGE_RATIO = 5;    // Upper over lower high-set range
  localparam logic [6:0] SCALE_1   = 7'h01;
  localparam logic [6:0] SCALE_10  = 7'h0a;
  localparam logic [6:0] SCALE_100 = 7'h64;

  // ----------------------------------------------------------------
  // Switch bit positions and reset values
  // ----------------------------------------------------------------
  localparam int SW_LRANGE = 0;  // Bits 1 and 2
  localparam int SW_IDMT   = 2;
  localparam int SW_LATCH  = 3;
  localparam int SW_DOUBLE = 4;
  localparam int SW_HRANGE = 5;
  localparam int SW_HDLY   = 6;  // Bits 7 and 8
  localparam int BR_LOW    = 0;
  localparam int BR_HIGH   = 1;
  localparam logic [9:0] FAULT_CODE_RST = 10'h000;

  // ----------------------------------------------------------------
  // Trip-test selection and sequencer states
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_LS  = 3'h0;
  localparam logic [2:0] SEL_LT  = 3'h1;
  localparam logic [2:0] SEL_HS  = 3'h2;
  localparam logic [2:0] SEL_HT  = 3'h3;
  localparam logic [2:0] SEL_IRF = 3'h4;

  typedef enum logic [1:0] {
    ST_NORMAL    = 2'b00,
    ST_TEST      = 2'b01,
    ST_IRF_WAIT  = 2'b10,
    ST_IRF_PULSE = 2'b11
  } test_state_t;

endpackage

// ==== hw/pin_sync.sv ====
// Three-stage synchroniser for a group of slow pins.
// Assumes pins are asynchronous to mclk and change far slower than it.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] q_ff;
  logic [WIDTH-1:0] nxt_q;

  // ----------------------------------------------------------------
  // Accept a change only once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_q[i] = s3_ff[i];
      end
    end
  end

  // Stage one feeds stage two only, so no metastable value leaks out
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff  <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= nxt_q;
    end
  end

  assign pin_out = q_ff;

endmodule
`default_nettype wire

// ==== dv/panel_model.sv ====
// Model of the front end and panel: one phase level and two buttons.
// Assumes the bench calls drive; changes land just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module panel_model (
  input  wire logic   mclk,
  output logic [11:0] phase,
  output logic        step_btn,
  output logic        reset_btn
);
  initial begin
    phase = 12'h000;
    step_btn = 1'b0;
    reset_btn = 1'b0;
  end
  // Set all levels together, then hold them for n cycles
  task automatic drive(input logic [11:0] p, input logic s, input logic r, input int n);
    @(posedge mclk);
    phase <= p;
    step_btn <= s;
    reset_btn <= r;
    repeat (n) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_overcurrent_logic.sv ====
// Bench: stage timing, blocking, lamps, fault code and trip-test.
// Assumes TICK_DIV of 4, so one second is 4000 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb_overcurrent_logic;
  import overcurrent_pkg::*;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic [11:0] ph;
  logic       stp, rsb, lss, lst, hss, hst, alm;
  logic       blk = 1'b0;
  logic       inf = 1'b0;
  logic       flt = 1'b0;
  logic       ser = 1'b0;
  logic       reg0 = 1'b0;
  logic [1:0] route = 2'h1;
  logic       hblk = 1'b0;
  logic       serb = 1'b0;
  logic [2:0] pen = 3'h7;
  logic [3:0] latch = 4'h2;
  logic [7:0] sw = 8'h20;
  logic       isup, dflash, linv, fcv;
  logic [1:0] lcg;
  logic [1:0] yel, red;
  logic [3:0] knob;
  logic [9:0] fcode;
  int         fail_count = 0;
  int         checks = 0;
  int         cyc = 0;
  always #50 mclk = ~mclk;
  panel_model pm (.mclk(mclk), .phase(ph), .step_btn(stp), .reset_btn(rsb));
  overcurrent_logic #(.TICK_DIV(4)) dut (.mclk(mclk), .rst_n(rst_n), .phase_a(ph),
    .phase_b(ph), .phase_c(ph), .phase_en(pen), .low_start_set(12'h064),
    .high_start_set(12'h190), .high_set_infinite(inf), .low_delay_set(12'h005),
    .high_delay_set(12'h005), .ind_latch_cfg(latch), .step_btn(stp), .reset_btn(rsb),
    .low_stage_block_in(blk), .high_stage_block_in(hblk), .block_route_switches(route),
    .front_function_switches(sw), .reg0_shown(reg0), .serial_reset_cmd_a(ser),
    .serial_reset_cmd_b(serb), .internal_fault(flt), .internal_fault_code(10'h123),
    .low_stage_start(lss), .low_stage_trip(lst), .high_stage_start(hss),
    .high_stage_trip(hst), .self_supervision_alarm(alm), .ind_yellow(yel),
    .ind_red(red), .ind_supervision(isup), .digit_flash(dflash), .knob_flash(knob),
    .low_curve_group(lcg), .low_inverse_mode(linv), .fault_code_valid(fcv),
    .fault_code(fcode));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard above the whole sequence, which needs about 80000 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    pm.drive(12'h0c8, 1'b0, 1'b0, 60);
    check({8'h0, lss, lst}, 10'h3);
    check({9'h0, hss}, 10'h0);
    blk <= 1'b1;
    pm.drive(12'h0c8, 1'b0, 1'b0, 30);
    check({8'h0, lss, red[0]}, 10'h1);
    serb <= 1'b1;
    @(posedge mclk);
    serb <= 1'b0;
    inf <= 1'b1;
    pm.drive(12'hfff, 1'b0, 1'b0, 60);
    check({8'h0, red[0], hss}, 10'h0);
    inf <= 1'b0;
    hblk <= 1'b1;
    route <= 2'h3;
    pm.drive(12'hfff, 1'b0, 1'b0, 30);
    check({9'h0, hss}, 10'h0);
    hblk <= 1'b0;
    latch <= 4'ha;
    pm.drive(12'hfff, 1'b0, 1'b0, 60);
    check({9'h0, hss}, 10'h1);
    check({9'h0, red[1]}, 10'h1);
    pen <= 3'h0;
    pm.drive(12'hfff, 1'b0, 1'b0, 30);
    check({9'h0, hss}, 10'h0);
    pen <= 3'h7;
    $display("stage tests done");
    flt <= 1'b1;
    pm.drive(12'h000, 1'b0, 1'b0, 10);
    check({8'h0, alm, isup}, 10'h3);
    check({9'h0, red[1]}, 10'h1);
    flt <= 1'b0;
    ser <= 1'b1;
    sw <= 8'h26;
    pm.drive(12'h000, 1'b0, 1'b1, 10);
    ser <= 1'b0;
    pm.drive(12'h000, 1'b0, 1'b0, 20);
    check(fcode, 10'h123);
    check({9'h0, fcv}, 10'h1);
    check({9'h0, red[1]}, 10'h0);
    check({7'h0, linv, lcg}, 10'h6);
    sw <= 8'h20;
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    pm.drive(12'h000, 1'b0, 1'b0, 10);
    check({8'h0, fcv, alm}, 10'h0);
    $display("fault tests done");
    reg0 <= 1'b1;
    pm.drive(12'h000, 1'b0, 1'b1, 40040);
    pm.drive(12'h000, 1'b0, 1'b0, 20);
    check({6'h0, knob}, 10'h1);
    check({9'h0, dflash}, 10'h1);
    pm.drive(12'h000, 1'b1, 1'b1, 20);
    check({8'h0, lss, yel[0]}, 10'h3);
    pm.drive(12'h000, 1'b0, 1'b0, 20);
    check({9'h0, lss}, 10'h0);
    pm.drive(12'h000, 1'b0, 1'b1, 4040);
    pm.drive(12'h000, 1'b0, 1'b0, 20);
    check({6'h0, knob}, 10'h2);
    pm.drive(12'h000, 1'b1, 1'b1, 20);
    check({8'h0, lst, red[0]}, 10'h3);
    pm.drive(12'h000, 1'b0, 1'b0, 20);
    pm.drive(12'h000, 1'b0, 1'b1, 4040);
    pm.drive(12'h000, 1'b1, 1'b1, 20);
    check({8'h0, hss, yel[1]}, 10'h3);
    pm.drive(12'h000, 1'b0, 1'b0, 20);
    pm.drive(12'h000, 1'b0, 1'b1, 4040);
    pm.drive(12'h000, 1'b1, 1'b1, 20);
    check({8'h0, hst, red[1]}, 10'h3);
    pm.drive(12'h000, 1'b0, 1'b0, 20);
    pm.drive(12'h000, 1'b0, 1'b1, 4040);
    pm.drive(12'h000, 1'b0, 1'b0, 20);
    check({6'h0, knob}, 10'h0);
    pm.drive(12'h000, 1'b1, 1'b0, 40);
    pm.drive(12'h000, 1'b0, 1'b0, 19000);
    check({9'h0, alm}, 10'h0);
    pm.drive(12'h000, 1'b0, 1'b0, 1400);
    check({8'h0, alm, isup}, 10'h3);
    pm.drive(12'h000, 1'b0, 1'b0, 2000);
    check({8'h0, alm, dflash}, 10'h0);
    $display("trip-test done");
    complete_run();
  end
endmodule
`default_nettype wire
